// *** include/ext_irq_pkg.sv ***
// Purpose: constants and types for the external line interrupt/event block
// Assumes: single clock, word-wide register port, 19 lines by default
// Notes: offsets are byte addresses on the plain register port
package ext_irq_pkg;

  localparam int unsigned NUM_LINES = 19;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_IRQ_MASK = 8'h00;
  localparam logic [7:0] OFF_EVT_MASK = 8'h04;
  localparam logic [7:0] OFF_RISE_EN = 8'h08;
  localparam logic [7:0] OFF_FALL_EN = 8'h0c;
  localparam logic [7:0] OFF_SW_TRIG = 8'h10;
  localparam logic [7:0] OFF_PENDING = 8'h14;
  localparam logic [7:0] OFF_ISTAT = 8'h18;
  localparam logic [7:0] OFF_SUM_MASK = 8'h1c;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // status bits of the block's own summary interrupt
  localparam int unsigned ST_PEND_SET = 0;
  localparam int unsigned ST_EVT_SENT = 1;
  localparam int unsigned ST_SW_TRIG = 2;
  localparam int unsigned ST_W = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

endpackage

// *** src/external_irq_event_ctrl.sv ***
// Purpose: external line interrupt and event controller
// Assumes: pins synchronous-ish, resynchronised here; one 200 MHz clock
// Notes: pending bits clear by writing 1; event pulses bypass handlers
//
// Function
// - only pin-driven external lines are handled by this block
// - allowed interrupt plus matching edge sets the line pending bit
// - writing 1 to pending clears bit and its request
// - enabled event plus matching edge gives one pulse, no pending
// - software trigger with event enabled gives an event pulse
// - software trigger with interrupt allowed sets the pending bit
// - event pulses drive hardware directly, not via any handler
// - interrupt mask per line: 0 blocks, 1 passes
// - event mask per line: 0 blocks, 1 passes
// - rising and falling enables may both be set
// - rising edge during rising-enable write is ignored
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module external_irq_event_ctrl
  import ext_irq_pkg::*;
#(
  parameter int unsigned LINES = NUM_LINES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // external lines
  input wire logic [LINES-1:0] i_ext_line,
  // to nested_vector_controller and wake-up logic
  output logic [LINES-1:0] o_irq_req,
  output logic [LINES-1:0] o_evt_pulse,
  output logic o_evt_any,
  output logic o_irq
);

  // the line vector must fit one register word
  if (LINES < 1 || LINES > DATA_W) begin : g_bad_lines
    $error("LINES must be 1..32");
  end

  reg_req_type req;
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // ----------------------------------------------------------------
  // line synchroniser and edge detect
  // ----------------------------------------------------------------
  logic [LINES-1:0] sync1_q, sync2_q, prev_q;
  logic [LINES-1:0] rise, fall;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= i_ext_line;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [LINES-1:0] irq_mask_q, irq_mask_d;
  logic [LINES-1:0] evt_mask_q, evt_mask_d;
  logic [LINES-1:0] rise_en_q, rise_en_d;
  logic [LINES-1:0] fall_en_q, fall_en_d;
  logic [ST_W-1:0] sum_mask_q, sum_mask_d;

  always_comb begin
    irq_mask_d = irq_mask_q;
    evt_mask_d = evt_mask_q;
    rise_en_d = rise_en_q;
    fall_en_d = fall_en_q;
    sum_mask_d = sum_mask_q;
    if (req.wr) begin
      unique case (req.addr)
        OFF_IRQ_MASK: irq_mask_d = req.wdata[LINES-1:0];
        OFF_EVT_MASK: evt_mask_d = req.wdata[LINES-1:0];
        OFF_RISE_EN: rise_en_d = req.wdata[LINES-1:0];
        OFF_FALL_EN: fall_en_d = req.wdata[LINES-1:0];
        OFF_SUM_MASK: sum_mask_d = req.wdata[ST_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      irq_mask_q <= REG_RESET[LINES-1:0];
      evt_mask_q <= REG_RESET[LINES-1:0];
      rise_en_q <= REG_RESET[LINES-1:0];
      fall_en_q <= REG_RESET[LINES-1:0];
      sum_mask_q <= REG_RESET[ST_W-1:0];
    end else begin
      irq_mask_q <= irq_mask_d;
      evt_mask_q <= evt_mask_d;
      rise_en_q <= rise_en_d;
      fall_en_q <= fall_en_d;
      sum_mask_q <= sum_mask_d;
    end
  end

  // ----------------------------------------------------------------
  // trigger, pending and event logic
  // ----------------------------------------------------------------
  logic rise_wr;
  logic [LINES-1:0] hw_trig, sw_trig, irq_set, evt_set, pend_clr;
  logic [LINES-1:0] pend_q, pend_d;
  logic [LINES-1:0] evt_q, evt_d;
  logic evt_any_q, evt_any_d;

  assign rise_wr = req.wr && (req.addr == OFF_RISE_EN);
  // rising edge lost when rising enable is being written
  assign hw_trig = (rise & rise_en_q & {LINES{~rise_wr}})
                 | (fall & fall_en_q);
  assign sw_trig = (req.wr && req.addr == OFF_SW_TRIG)
                 ? req.wdata[LINES-1:0] : '0;
  assign irq_set = (hw_trig | sw_trig) & irq_mask_q;
  assign evt_set = (hw_trig | sw_trig) & evt_mask_q;
  assign pend_clr = (req.wr && req.addr == OFF_PENDING)
                  ? req.wdata[LINES-1:0] : '0;

  always_comb begin
    // write-1 clear; a same-cycle set wins
    pend_d = (pend_q & ~pend_clr) | irq_set;
    // event pulse lasts one cycle straight to hardware
    evt_d = evt_set;
    evt_any_d = |evt_set;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pend_q <= '0;
      evt_q <= '0;
      evt_any_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      evt_q <= evt_d;
      evt_any_q <= evt_any_d;
    end
  end

  // requests straight from the pending bits, set by pin edges or software trigger
  assign o_irq_req = pend_q;
  assign o_evt_pulse = evt_q;
  assign o_evt_any = evt_any_q;

  // ----------------------------------------------------------------
  // summary status, mask and read port
  // ----------------------------------------------------------------
  logic [ST_W-1:0] istat_q, istat_d, ev_now;
  logic istat_rd;
  logic irq_q, irq_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  assign ev_now[ST_PEND_SET] = |irq_set;
  assign ev_now[ST_EVT_SENT] = |evt_set;
  assign ev_now[ST_SW_TRIG] = |sw_trig;
  assign istat_rd = req.rd && (req.addr == OFF_ISTAT);

  always_comb begin
    // read clears, but a new event in the same cycle stays
    istat_d = (istat_rd ? '0 : istat_q) | ev_now;
    irq_d = |(istat_d & sum_mask_q);
    rdata_d = '0;
    if (req.rd) begin
      unique case (req.addr)
        OFF_IRQ_MASK: rdata_d[LINES-1:0] = irq_mask_q;
        OFF_EVT_MASK: rdata_d[LINES-1:0] = evt_mask_q;
        OFF_RISE_EN: rdata_d[LINES-1:0] = rise_en_q;
        OFF_FALL_EN: rdata_d[LINES-1:0] = fall_en_q;
        OFF_PENDING: rdata_d[LINES-1:0] = pend_q;
        OFF_ISTAT: rdata_d[ST_W-1:0] = istat_q;
        OFF_SUM_MASK: rdata_d[ST_W-1:0] = sum_mask_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      istat_q <= '0;
      irq_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      istat_q <= istat_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_irq = irq_q;
  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_chk
      a_pend_on_hw: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (rise[g] && rise_en_q[g] && !rise_wr && irq_mask_q[g])
          |=> pend_q[g])
        else $error("pending not set by rising edge");
      a_rise_en_off: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (rise[g] && !rise_en_q[g] && !sw_trig[g] && !pend_q[g])
          |=> !pend_q[g])
        else $error("pending set by disabled edge");
      a_pend_clear: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (pend_clr[g] && !irq_set[g]) |=> !pend_q[g] && !o_irq_req[g])
        else $error("pending not cleared by write 1");
      a_pend_hold: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (pend_q[g] && !pend_clr[g]) |=> pend_q[g])
        else $error("pending dropped without clear");
      a_evt_pulse: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (fall[g] && fall_en_q[g] && evt_mask_q[g]) |=> o_evt_pulse[g])
        else $error("event pulse missing");
      a_evt_no_pend: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (!irq_mask_q[g] && !pend_q[g] && !sw_trig[g]) |=> !pend_q[g])
        else $error("masked line set pending");
      a_sw_event: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (sw_trig[g] && evt_mask_q[g]) |=> o_evt_pulse[g])
        else $error("software event missing");
      a_sw_irq: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (sw_trig[g] && irq_mask_q[g]) |=> pend_q[g])
        else $error("software irq missing");
      a_irq_mask: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (!irq_mask_q[g] && pend_clr[g]) |=> !pend_q[g])
        else $error("masked line pending after clear");
      a_evt_mask: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (!evt_mask_q[g]) |=> !o_evt_pulse[g])
        else $error("event passed while masked");
      a_fall_pend: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (fall[g] && fall_en_q[g] && irq_mask_q[g]) |=> pend_q[g])
        else $error("pending not set by falling edge");
      a_rise_ignore: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (rise[g] && rise_wr && !fall_en_q[g] && !sw_trig[g])
          |=> !o_evt_pulse[g])
        else $error("rising edge recognised during write");
      a_rise_lost: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        (rise[g] && rise_wr && !pend_q[g]) |=> !pend_q[g])
        else $error("pending set by edge during write");
      a_edge_sync: assert property (
        @(posedge i_mclk) disable iff (i_rst)
        ($rose(sync2_q[g])) |-> rise[g] ##1 !rise[g])
        else $error("edge strobe not one cycle");
    end
  endgenerate

  // whole-word checks
  a_sync_delay: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (!$past(i_rst) && !$past(i_rst, 2))
      |-> sync2_q == $past(i_ext_line, 2))
    else $error("line synchroniser delay wrong");
  a_evt_any: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    o_evt_any == (|o_evt_pulse))
    else $error("event summary differs from pulses");
  a_irq_mask_wr: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (i_wr && i_addr == OFF_IRQ_MASK)
      |=> irq_mask_q == $past(i_wdata[LINES-1:0]))
    else $error("interrupt mask write lost");
  a_rise_en_wr: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (i_wr && i_addr == OFF_RISE_EN)
      |=> rise_en_q == $past(i_wdata[LINES-1:0]))
    else $error("rising enable write lost");
  a_rdata_pend: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (i_rd && i_addr == OFF_PENDING)
      |=> o_rdata[LINES-1:0] == $past(pend_q))
    else $error("pending read data wrong");
  a_rdata_idle: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    !$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside read cycle");
  a_sum_irq: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    o_irq == (|(istat_q & $past(sum_mask_q))))
    else $error("summary interrupt level wrong");
  a_stat_clear: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (istat_rd && ev_now == '0) |=> istat_q == '0)
    else $error("status not cleared by read");

endmodule

// *** sim/nvc_model.sv ***
// Purpose: far-side model of vector controller and wake-up logic
// Assumes: same clock and reset as the line controller
// Notes: every cycle with any event pulse counts as one wake-up, however many lines pulse in it
`timescale 1ns/10ps
module nvc_model
  import ext_irq_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // from the line controller
  input wire logic i_evt_any,
  // observation
  output logic [15:0] o_wake_cnt
);
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) o_wake_cnt <= 16'h0000;
    else o_wake_cnt <= o_wake_cnt + 16'(i_evt_any);
  end
endmodule

// *** sim/external_irq_event_ctrl_tb.sv ***
// Purpose: self-checking bench for the external line controller
// Assumes: 200 MHz clock, reset held 10 cycles, xorshift seed 25329
// Notes: inputs change by nonblocking assignment at rising edges
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module external_irq_event_ctrl_tb
  import ext_irq_pkg::*;
;
  localparam logic [NUM_LINES-1:0] ALL = '1;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  // seed 25329
  logic [31:0] i_wdata = 32'h0, o_rdata, rng = 32'h0000_62f1;
  logic [NUM_LINES-1:0] i_ext_line = '0, o_irq_req, o_evt_pulse, acc;
  logic o_evt_any, o_irq;
  logic [15:0] wake_cnt;
  int num_errors = 0, samples_checked = 0;

  external_irq_event_ctrl #(.LINES(NUM_LINES)) dut (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_line(i_ext_line),
    .o_irq_req(o_irq_req), .o_evt_pulse(o_evt_pulse),
    .o_evt_any(o_evt_any), .o_irq(o_irq));
  nvc_model far (.i_mclk(i_mclk), .i_rst(i_rst), .i_evt_any(o_evt_any),
    .o_wake_cnt(wake_cnt));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [NUM_LINES-1:0] edg(
    input logic [NUM_LINES-1:0] o, n, r, f);
    return (~o & n & r) | (o & ~n & f);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    `CHK("rdata", e, o_rdata)
  endtask
  // collects event pulses over a fixed settling span
  task automatic settle(input int n);
    acc = '0;
    repeat (n) begin
      @(posedge i_mclk);
      #1;
      acc = acc | o_evt_pulse;
    end
  endtask
  // pins move on a rising edge, like every other input
  task automatic pins(input logic [NUM_LINES-1:0] v);
    @(posedge i_mclk);
    i_ext_line <= v;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial forever #2.5 i_mclk = ~i_mclk;
  initial begin
    #200000;
    num_errors++;
    conclude();
  end

  initial begin
    logic [NUM_LINES-1:0] m, e, g, o, n, r, f;
    int lost, wakes;
    wakes = 0;
    lost = 0;
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int a = 0; a < 9; a++) rd(8'(a * 4), 32'h0);
    for (int a = 0; a < 4; a++) begin
      rng = xs(rng);
      wr(8'(a * 4), rng);
      rd(8'(a * 4), 32'(rng[NUM_LINES-1:0]));
    end
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      m = rng[NUM_LINES-1:0];
      rng = xs(rng);
      e = rng[NUM_LINES-1:0];
      rng = xs(rng);
      g = (i == 0) ? ALL : rng[NUM_LINES-1:0];
      f = rng[31:32-NUM_LINES];
      wr(OFF_IRQ_MASK, 32'(m));
      wr(OFF_EVT_MASK, 32'(e));
      wr(OFF_PENDING, 32'(ALL));
      wr(OFF_SW_TRIG, 32'(g));
      `CHK("evt", e & g, o_evt_pulse)
      `CHK("req", m & g, o_irq_req)
      wakes += int'((e & g) != '0);
      @(posedge i_mclk);
      #1;
      `CHK("evt once", '0, o_evt_pulse)
      rd(OFF_PENDING, 32'(m & g));
      wr(OFF_PENDING, 32'(f));
      `CHK("clear", m & g & ~f, o_irq_req)
    end
    `CHK("wakes", 16'(wakes), wake_cnt)
    $display("test software trigger done");
    wr(OFF_IRQ_MASK, 32'(ALL));
    wr(OFF_EVT_MASK, 32'(ALL));
    for (int i = 0; i < 20; i++) begin
      rng = xs(rng);
      r = (i == 0) ? ALL : rng[NUM_LINES-1:0];
      f = (i == 0) ? ALL : rng[31:32-NUM_LINES];
      rng = xs(rng);
      n = (i == 0) ? ~i_ext_line : rng[NUM_LINES-1:0];
      wr(OFF_RISE_EN, 32'(r));
      wr(OFF_FALL_EN, 32'(f));
      wr(OFF_PENDING, 32'(ALL));
      o = i_ext_line;
      pins(n);
      settle(6);
      `CHK("pin evt", edg(o, n, r, f), acc)
      `CHK("pin req", edg(o, n, r, f), o_irq_req)
    end
    $display("test pin edges done");
    wr(OFF_FALL_EN, 32'h0);
    // only the delay that lands the write on the strobe loses the edge
    for (int d = 0; d < 6; d++) begin
      pins('0);
      settle(6);
      wr(OFF_PENDING, 32'(ALL));
      pins(ALL);
      repeat (d) @(posedge i_mclk);
      wr(OFF_RISE_EN, 32'(ALL));
      settle(6);
      lost += int'(o_irq_req[0] === 1'b0);
    end
    `CHK("lost edges", 1, lost)
    $display("test rising enable write done");
    wr(OFF_SUM_MASK, 32'h7);
    // the summary level follows a mask write one edge later
    @(posedge i_mclk);
    #1;
    `CHK("irq", 1'b1, o_irq)
    rd(OFF_ISTAT, 32'h7);
    @(posedge i_mclk);
    #1;
    `CHK("irq off", 1'b0, o_irq)
    wr(OFF_SUM_MASK, 32'h0);
    wr(OFF_SW_TRIG, 32'h1);
    settle(2);
    `CHK("irq masked", 1'b0, o_irq)
    rd(OFF_ISTAT, 32'h7);
    $display("test summary done");
    conclude();
  end
endmodule
